// *** rtl/shockproof_command_status_control.sv ***
`timescale 1ns/10ps
`include "shockproof_params.svh"

module shockproof_command_status_control
	import shockproof_pkg::*;
#(
	parameter int ADDR_W = 18
) (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_host_shift_clock,
	input wire logic i_host_serial_data,
	input wire logic i_host_latch_strobe,
	input wire logic i_dsp_overflow_in,
	input wire logic i_frame_clock_in,
	input wire logic i_block_clock_in,
	input wire logic i_mute_pin,
	input wire logic [3:0] i_ext_port_level,
	input wire logic i_write_step,
	input wire logic i_read_step,
	input wire logic i_conform_detect,
	input wire logic i_connect_done,
	input wire logic i_left_word_start,
	output logic o_host_sense_out,
	output ctrl_s o_ctrl,
	output logic [7:0] o_gain,
	output logic [ADDR_W-1:0] o_write_pointer,
	output logic [ADDR_W-1:0] o_read_pointer,
	output logic [ADDR_W-1:0] o_valid_write_pointer
);

	// Pointer width must hold a real buffer and stay countable.
	if (ADDR_W < 4 || ADDR_W > 24) begin : g_bad_width
		$error("ADDR_W must lie between 4 and 24");
	end

	// Pin indices inside the synchronised group.
	localparam int P_STROBE = 0;
	localparam int P_SHIFT = 1;
	localparam int P_FRAME = 2;
	localparam int P_FLAG = 3;
	localparam int P_BLOCK = 4;
	localparam int P_MUTE = 5;
	localparam int P_EXT = 6;
	localparam int PINS = 10;

	logic [PINS-1:0] pins_s;
	logic [PINS-1:0] pins_d;
	logic [15:0] link_frame;
	host_frame_s frame;

	// Host frame register on the link clock.
	host_frame_shifter #(
		.FRAME_W(16)
	) u_shifter (
		.i_host_shift_clock(i_host_shift_clock),
		.i_arst_n(i_arst_n),
		.i_host_serial_data(i_host_serial_data),
		.o_frame(link_frame)
	);

	// The ten pin levels of this group pass two flip-flops before any logic reads them.
	pin_sync #(
		.WIDTH(PINS)
	) u_pin_sync (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_async({i_ext_port_level, i_mute_pin, i_block_clock_in, i_dsp_overflow_in,
			i_frame_clock_in, i_host_shift_clock, i_host_latch_strobe}),
		.o_sync(pins_s)
	);

	// Delayed copy of the synchronised pins for edge detection.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pins_d <= '0;
		end else begin
			pins_d <= pins_s;
		end
	end

	// Edges of the synchronised pins.
	wire strobe_rise = pins_s[P_STROBE] & ~pins_d[P_STROBE];
	wire shift_fall = ~pins_s[P_SHIFT] & pins_d[P_SHIFT];
	wire frame_rise = pins_s[P_FRAME] & ~pins_d[P_FRAME];
	wire frame_fall = ~pins_s[P_FRAME] & pins_d[P_FRAME];
	wire block_fall = ~pins_s[P_BLOCK] & pins_d[P_BLOCK];
	wire flag_s = pins_s[P_FLAG];
	wire mute_pin_s = pins_s[P_MUTE];
	wire [3:0] ext_s = pins_s[P_EXT +: 4];

	// The frame is quiet once the strobe has risen, so it is taken whole.
	assign frame = host_frame_s'(link_frame);

	// Command decode on the synchronised strobe edge.
	wire wr_ms = strobe_rise && frame.addr == `SP_ADDR_MEMSYS;
	wire wr_att = strobe_rise && frame.addr == `SP_ADDR_ATT_MUTE;
	wire wr_level = strobe_rise && frame.addr == `SP_ADDR_ATT_LEVEL;
	wire wr_opt = strobe_rise && frame.addr == `SP_ADDR_OPTION;
	wire rd_s1 = frame.addr == `SP_ADDR_STATUS_ONE;
	wire rd_s2 = frame.addr == `SP_ADDR_STATUS_TWO;
	wire rd_ext = frame.addr == `SP_ADDR_EXT_PORT;
	wire rd_any = strobe_rise && (rd_s1 || rd_s2 || rd_ext);

	// Fields of a memory-system command in flight.
	wire [7:0] cmd = frame.data;
	wire cmd_enc_en = cmd[`SP_MS_ENCODE_ENABLE];
	wire cmd_on = cmd[`SP_MS_MEMORY_SYSTEM_ON];
	wire [1:0] cmd_mode = {cmd[`SP_MS_CONNECT_MODE_HI], cmd[`SP_MS_CONNECT_MODE_LO]};
	wire wclr = wr_ms && cmd[`SP_MS_WRITE_ADDR_CLEAR];
	wire rclr = wr_ms && cmd[`SP_MS_READ_ADDR_CLEAR];
	wire any_clr = wclr || rclr;
	wire conn_start = wr_ms && cmd_mode != 2'b00;
	wire conn_stop = wr_ms && cmd_mode == 2'b00;
	wire commit = wr_ms && cmd[`SP_MS_SUBCODE_VALID_COMMIT];
	wire mem_off = wr_ms && !cmd_on;

	// Stored settings.
	logic [7:0] ms_reg;
	logic [7:0] att_mute;
	logic [7:0] att_level;
	logic [7:0] option;

	// Status state.
	logic jitter_error_flag;
	logic overflow_once_flag;
	logic connect_busy_flag;
	logic encode_internal_stop;
	logic decode_internal_stop;
	logic buffer_full_flag;
	logic encoding_state;
	logic empty_q;
	logic [ADDR_W-1:0] latched_pointer;

	// Serial readout state.
	logic [7:0] sense_shift;
	logic [3:0] read_cnt;
	logic reading_s1;

	// Empty is a pure pointer match; decode runs only with data.
	wire buffer_empty_flag = o_valid_write_pointer == o_read_pointer;
	wire next_decoding = ms_reg[`SP_MS_DECODE_ENABLE] && !buffer_empty_flag;

	// A write step that lands on the read pointer has passed it.
	wire [ADDR_W-1:0] wp_plus = o_write_pointer + ADDR_W'(1);
	wire ovf_event = i_write_step && wp_plus == o_read_pointer;

	// Jitter condition chosen by level mode and polarity.
	logic jitter_set;
	always_comb begin
		case ({option[`SP_OPT_FLAG_LEVEL_MODE], option[`SP_OPT_FLAG_POLARITY_SELECT]})
			2'b00: jitter_set = frame_fall && !flag_s;
			2'b01: jitter_set = frame_rise && !flag_s;
			2'b10: jitter_set = !flag_s;
			2'b11: jitter_set = flag_s;
			default: jitter_set = 1'b0;
		endcase
	end

	// Readout of status word one ends on the eighth falling shift edge.
	wire read_done = shift_fall && read_cnt == 4'h1;
	wire s1_read_done = read_done && reading_s1;

	// Encode request acceptance and the direct join of a running connect.
	wire enc_accept = wr_ms && cmd_enc_en && cmd_on && !jitter_error_flag
		&& !buffer_full_flag && cmd_mode == 2'b00;
	wire direct_join = enc_accept && connect_busy_flag;
	wire join_done = i_conform_detect || i_connect_done || direct_join;

	// Encoding: every clear outranks every set.
	wire enc_clear = jitter_error_flag || buffer_full_flag || ovf_event
		|| (wr_ms && (!cmd_enc_en || cmd_mode != 2'b00 || !cmd_on));
	wire enc_set = enc_accept || i_conform_detect || i_connect_done;
	wire next_encoding = enc_clear ? 1'b0 : (enc_set ? 1'b1 : encoding_state);

	// Connect busy set by a start, which wins; a stop command, encode enable, conform detect or connect done ends it.
	wire busy_clear = i_conform_detect || i_connect_done || conn_stop
		|| (wr_ms && cmd_enc_en);
	wire next_busy = conn_start || (connect_busy_flag && !busy_clear);

	// Sticky flags: an event in a clearing cycle still sets the flag.
	wire next_jitter = jitter_set || (jitter_error_flag && !(s1_read_done || mem_off));
	wire next_ovf_once = ovf_event || (overflow_once_flag && !(s1_read_done || any_clr));
	wire next_enc_stop = jitter_set || ovf_event
		|| (encode_internal_stop && !(join_done || any_clr));
	wire dec_stop_set = buffer_empty_flag && !empty_q;
	wire next_dec_stop = dec_stop_set
		|| (decode_internal_stop && !(s1_read_done || any_clr));
	wire next_full = ovf_event || (buffer_full_flag && !(i_read_step || any_clr));

	// Readable words.
	logic [7:0] status_one;
	logic [7:0] status_two;
	always_comb begin
		status_one = 8'h00;
		status_one[`SP_S1_JITTER_ERROR] = jitter_error_flag;
		status_one[`SP_S1_OVERFLOW_ONCE] = overflow_once_flag;
		status_one[`SP_S1_CONNECT_BUSY] = connect_busy_flag;
		status_one[`SP_S1_ENCODE_STOP] = encode_internal_stop;
		status_one[`SP_S1_DECODE_STOP] = decode_internal_stop;
		status_two = 8'h00;
		status_two[`SP_S2_BUFFER_EMPTY] = buffer_empty_flag;
		status_two[`SP_S2_BUFFER_FULL] = buffer_full_flag;
		status_two[`SP_S2_ENCODING] = encoding_state;
		status_two[`SP_S2_DECODING] = o_ctrl.decoding_state;
	end
	wire [7:0] ext_word = {4'h0, ext_s};
	wire [7:0] read_word = rd_s1 ? status_one : (rd_s2 ? status_two : ext_word);

	// Compression mode from the one-hot selection bits.
	wire [3:0] comp_sel = option[`SP_OPT_SEL_FULL_BIT:`SP_OPT_SEL_FOUR_BIT];
	wire compress_mode_e next_comp = comp_sel == 4'b0001 ? COMP_FOUR_BIT
		: comp_sel == 4'b0010 ? COMP_FIVE_BIT
		: comp_sel == 4'b1000 ? COMP_FULL_BIT : COMP_SIX_BIT;

	// Gain target and mute sources.
	wire hard_mute = att_mute[`SP_AM_HARD_MUTE] || mute_pin_s;
	wire soft_mute = att_mute[`SP_AM_SOFT_MUTE];
	wire [7:0] gain_target = att_mute[`SP_AM_ATTENUATOR_ENABLE] ? att_level : `SP_UNITY_GAIN;
	wire [7:0] soft_gain = o_gain > `SP_SOFT_STEP ? o_gain - `SP_SOFT_STEP : 8'h00;
	wire [7:0] next_gain = hard_mute ? 8'h00 : (soft_mute ? soft_gain : gain_target);

	// Register writes from the host.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ms_reg <= `SP_RST_MEMSYS;
			att_mute <= `SP_RST_ATT_MUTE;
			att_level <= `SP_RST_ATT_LEVEL;
			option <= `SP_RST_OPTION;
		end else begin
			if (wr_ms) begin
				ms_reg <= cmd;
			end
			if (wr_att) begin
				att_mute <= frame.data;
			end
			if (wr_level) begin
				att_level <= frame.data;
			end
			if (wr_opt) begin
				option <= frame.data;
			end
		end
	end

	// Status flags.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			jitter_error_flag <= 1'b0;
			overflow_once_flag <= 1'b0;
			connect_busy_flag <= 1'b0;
			encode_internal_stop <= 1'b0;
			decode_internal_stop <= 1'b0;
			buffer_full_flag <= 1'b0;
			encoding_state <= 1'b0;
			empty_q <= 1'b1;
		end else begin
			jitter_error_flag <= next_jitter;
			overflow_once_flag <= next_ovf_once;
			connect_busy_flag <= next_busy;
			encode_internal_stop <= next_enc_stop;
			decode_internal_stop <= next_dec_stop;
			buffer_full_flag <= next_full;
			encoding_state <= next_encoding;
			empty_q <= buffer_empty_flag;
		end
	end

	// Write pointer and its copy latched at each block-clock fall.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_write_pointer <= '0;
			latched_pointer <= '0;
		end else begin
			if (wclr) begin
				o_write_pointer <= '0;
			end else if (i_write_step) begin
				o_write_pointer <= wp_plus;
			end
			if (wclr) begin
				latched_pointer <= '0;
			end else if (block_fall) begin
				latched_pointer <= o_write_pointer;
			end
		end
	end

	// Read and valid write pointers.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_read_pointer <= '0;
			o_valid_write_pointer <= '0;
		end else begin
			if (rclr) begin
				o_read_pointer <= '0;
			end else if (i_read_step) begin
				o_read_pointer <= o_read_pointer + ADDR_W'(1);
			end
			if (wclr) begin
				o_valid_write_pointer <= '0;
			end else if (commit) begin
				o_valid_write_pointer <= latched_pointer;
			end
		end
	end

	// Status readout: bits leave MSB first on falling shift edges.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sense_shift <= 8'h00;
			read_cnt <= 4'h0;
			reading_s1 <= 1'b0;
		end else if (rd_any) begin
			sense_shift <= read_word;
			read_cnt <= `SP_READ_BITS;
			reading_s1 <= rd_s1;
		end else if (shift_fall && read_cnt != 4'h0) begin
			sense_shift <= {sense_shift[6:0], 1'b0};
			read_cnt <= read_cnt - 4'h1;
		end
	end
	assign o_host_sense_out = sense_shift[7];

	// Control levels for the datapath.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_ctrl <= '{memory_system_on: 1'b0, encoding_state: 1'b0, decoding_state: 1'b0,
				attenuator_enable: 1'b0, reduced_compare: 1'b0,
				compress_mode: COMP_SIX_BIT, connect_start: 1'b0, connect_mode: 2'b00};
		end else begin
			o_ctrl.memory_system_on <= wr_ms ? cmd_on : ms_reg[`SP_MS_MEMORY_SYSTEM_ON];
			o_ctrl.encoding_state <= next_encoding;
			o_ctrl.decoding_state <= next_decoding;
			o_ctrl.attenuator_enable <= att_mute[`SP_AM_ATTENUATOR_ENABLE];
			o_ctrl.reduced_compare <= att_mute[`SP_AM_REDUCED_COMPARE];
			o_ctrl.compress_mode <= next_comp;
			o_ctrl.connect_start <= conn_start;
			if (conn_start) begin
				o_ctrl.connect_mode <= cmd_mode;
			end
		end
	end

	// Gain moves only at the start of a left-channel word.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_gain <= `SP_UNITY_GAIN;
		end else if (i_left_word_start) begin
			o_gain <= next_gain;
		end
	end

endmodule

// *** shared/shockproof_params.svh ***
`ifndef SHOCKPROOF_PARAMS_SVH
`define SHOCKPROOF_PARAMS_SVH

// Command addresses carried in the first byte of a host frame.
`define SP_ADDR_MEMSYS 8'h80
`define SP_ADDR_ATT_MUTE 8'h83
`define SP_ADDR_ATT_LEVEL 8'h84
`define SP_ADDR_OPTION 8'h85
`define SP_ADDR_STATUS_ONE 8'h90
`define SP_ADDR_STATUS_TWO 8'h91
`define SP_ADDR_EXT_PORT 8'h93

// Memory-system command fields.
`define SP_MS_ENCODE_ENABLE 7
`define SP_MS_WRITE_ADDR_CLEAR 6
`define SP_MS_DECODE_ENABLE 5
`define SP_MS_READ_ADDR_CLEAR 4
`define SP_MS_CONNECT_MODE_HI 3
`define SP_MS_CONNECT_MODE_LO 2
`define SP_MS_SUBCODE_VALID_COMMIT 1
`define SP_MS_MEMORY_SYSTEM_ON 0

// Attenuation and mute fields.
`define SP_AM_ATTENUATOR_ENABLE 7
`define SP_AM_HARD_MUTE 6
`define SP_AM_SOFT_MUTE 5
`define SP_AM_REDUCED_COMPARE 3

// Option fields.
`define SP_OPT_FLAG_LEVEL_MODE 5
`define SP_OPT_FLAG_POLARITY_SELECT 4
`define SP_OPT_SEL_FULL_BIT 3
`define SP_OPT_SEL_SIX_BIT 2
`define SP_OPT_SEL_FIVE_BIT 1
`define SP_OPT_SEL_FOUR_BIT 0

// Status word one fields.
`define SP_S1_JITTER_ERROR 7
`define SP_S1_OVERFLOW_ONCE 6
`define SP_S1_CONNECT_BUSY 3
`define SP_S1_ENCODE_STOP 2
`define SP_S1_DECODE_STOP 1

// Status word two fields.
`define SP_S2_BUFFER_EMPTY 7
`define SP_S2_BUFFER_FULL 6
`define SP_S2_ENCODING 5
`define SP_S2_DECODING 4

// Reset values.
`define SP_RST_MEMSYS 8'h00
`define SP_RST_ATT_MUTE 8'h00
`define SP_RST_ATT_LEVEL 8'h40
`define SP_RST_OPTION 8'h04

// Gain and serial-read constants.
`define SP_UNITY_GAIN 8'h40
`define SP_SOFT_STEP 8'h01
`define SP_READ_BITS 4'h8

`endif

// *** shared/shockproof_pkg.sv ***
package shockproof_pkg;

	// Compression depth chosen by the option command.
	typedef enum logic [1:0] {
		COMP_FOUR_BIT,
		COMP_FIVE_BIT,
		COMP_SIX_BIT,
		COMP_FULL_BIT
	} compress_mode_e;

	// One host frame: command address then data byte.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} host_frame_s;

	// Control levels handed to the codec and memory datapath.
	typedef struct packed {
		logic memory_system_on;
		logic encoding_state;
		logic decoding_state;
		logic attenuator_enable;
		logic reduced_compare;
		compress_mode_e compress_mode;
		logic connect_start;
		logic [1:0] connect_mode;
	} ctrl_s;

endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/10ps
// Two-stage synchroniser for a group of unrelated pin levels.
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] stage_one;

	// The first stage feeds only the second.
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			stage_one <= '0;
			o_sync <= '0;
		end else begin
			stage_one <= i_async;
			o_sync <= stage_one;
		end
	end

endmodule

// *** rtl/host_frame_shifter.sv ***
`timescale 1ns/10ps
// Shift register on the host shift clock; holds the last frame bits.
module host_frame_shifter #(
	parameter int FRAME_W = 16
) (
	input wire logic i_host_shift_clock,
	input wire logic i_arst_n,
	input wire logic i_host_serial_data,
	output logic [FRAME_W-1:0] o_frame
);

	// Data is taken MSB first on each rising shift clock edge.
	always_ff @(posedge i_host_shift_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_frame <= '0;
		end else begin
			o_frame <= {o_frame[FRAME_W-2:0], i_host_serial_data};
		end
	end

endmodule

// *** dv/shockproof_command_status_control_props.sv ***
`timescale 1ns/10ps
// Ties pointer, gain and control outputs to the pulses and pins that move them.
module shockproof_props
	import shockproof_pkg::*;
#(
	parameter int ADDR_W = 18
) (
	input wire logic i_clock,
	input wire logic i_arst_n,
	input wire logic i_host_latch_strobe,
	input wire logic i_mute_pin,
	input wire logic i_write_step,
	input wire logic i_read_step,
	input wire logic i_left_word_start,
	input wire ctrl_s o_ctrl,
	input wire logic [7:0] o_gain,
	input wire logic [ADDR_W-1:0] o_write_pointer,
	input wire logic [ADDR_W-1:0] o_read_pointer,
	input wire logic [ADDR_W-1:0] o_valid_write_pointer
);
	// Every check runs on the system clock and rests during reset.
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	a_write_step_inc: assert property (i_write_step && !i_host_latch_strobe
		|=> o_write_pointer == $past(o_write_pointer) + 1'b1) else $error("write step lost.");
	a_read_step_inc: assert property (i_read_step && !i_host_latch_strobe
		|=> o_read_pointer == $past(o_read_pointer) + 1'b1) else $error("read step lost.");
	a_write_ptr_hold: assert property (!i_write_step && !i_host_latch_strobe
		|=> $stable(o_write_pointer)) else $error("write pointer moved alone.");
	a_valid_ptr_hold: assert property (!i_host_latch_strobe
		|=> $stable(o_valid_write_pointer)) else $error("valid pointer moved alone.");
	a_gain_left_only: assert property (!i_left_word_start
		|=> $stable(o_gain)) else $error("gain moved off word start.");
	a_hard_mute_zero: assert property (i_mute_pin [*4] ##0 i_left_word_start
		|=> o_gain == 8'h00) else $error("mute pin ignored.");
	a_connect_pulse: assert property (o_ctrl.connect_start
		|=> !o_ctrl.connect_start) else $error("connect start too long.");
	a_connect_no_encode: assert property (o_ctrl.connect_start
		|-> !o_ctrl.encoding_state) else $error("encoding during connect start.");
	a_off_no_encode: assert property (!o_ctrl.memory_system_on
		|-> !o_ctrl.encoding_state) else $error("encoding while memory off.");
	a_empty_no_decode: assert property ((o_valid_write_pointer == o_read_pointer) [*4]
		|-> !o_ctrl.decoding_state) else $error("decoding while empty.");
	c_connect: cover property (o_ctrl.connect_start);
	c_decoding: cover property (o_ctrl.decoding_state);
	c_muted: cover property (i_mute_pin && o_gain == 8'h00);
endmodule

bind shockproof_command_status_control shockproof_props #(.ADDR_W(ADDR_W)) i_props (
	.i_clock(i_clock), .i_arst_n(i_arst_n), .i_host_latch_strobe(i_host_latch_strobe),
	.i_mute_pin(i_mute_pin), .i_write_step(i_write_step), .i_read_step(i_read_step),
	.i_left_word_start(i_left_word_start), .o_ctrl(o_ctrl), .o_gain(o_gain),
	.o_write_pointer(o_write_pointer), .o_read_pointer(o_read_pointer),
	.o_valid_write_pointer(o_valid_write_pointer));

// *** dv/host_link_model.sv ***
`timescale 1ns/10ps
// Host end of the three-wire link; the shift clock stays low between frames.
module host_link_model (
	output logic o_shift_clock,
	output logic o_serial_data,
	output logic o_latch_strobe,
	input wire logic i_sense
);
	// Idle link at time zero.
	initial begin
		o_shift_clock = 0;
		o_serial_data = 0;
		o_latch_strobe = 0;
	end
	// One frame, address byte first, MSB first, then the strobe rises and stays up.
	task automatic send(input logic [7:0] a, input logic [7:0] d);
		logic [15:0] f;
		f = {a, d};
		#7;
		for (int i = 15; i >= 0; i--) begin
			o_serial_data = f[i];
			#40 o_shift_clock = 1;
			#40 o_shift_clock = 0;
		end
		o_serial_data = ~f[0]; // The released line shows no stale bit.
		#40 o_latch_strobe = 1;
		#100;
	endtask
	// A write frame; the strobe drops once the command has been taken.
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		send(a, d);
		o_latch_strobe = 0;
	endtask
	// A read frame and eight readout clocks; each bit is taken just before its falling edge.
	task automatic get(input logic [7:0] a, output logic [7:0] w);
		send(a, 8'h00);
		for (int i = 7; i >= 0; i--) begin
			#40 o_shift_clock = 1;
			#40 w[i] = i_sense;
			o_shift_clock = 0;
		end
		#60 o_latch_strobe = 0;
	endtask
endmodule

// *** dv/tb.sv ***
`timescale 1ns/10ps
module tb
	import shockproof_pkg::*;
;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic [4:0] exp;
	} row_s;
	logic clock = 0, arst_n = 0, flag_in = 1, fclk = 0, bclk = 1, mute = 0;
	logic wstep = 0, rstep = 0, conf = 0, cdone = 0, lws = 0, sck, sdat, ld, sense;
	logic [3:0] ext = 4'ha;
	logic [4:0] got;
	logic [7:0] gain, w;
	logic [17:0] wp, rp, vwp;
	ctrl_s ctrl;
	int fails = 0, cmp_count = 0, starts = 0;
	// Writes and the {on, attenuate, compare12, mode} levels each should leave.
	row_s rows [8] = '{
		'{8'h85, 8'h01, {3'b000, COMP_FOUR_BIT}},
		'{8'h85, 8'h02, {3'b000, COMP_FIVE_BIT}},
		'{8'h85, 8'h08, {3'b000, COMP_FULL_BIT}},
		'{8'h85, 8'h0c, {3'b000, COMP_SIX_BIT}},
		'{8'h85, 8'h00, {3'b000, COMP_SIX_BIT}},
		'{8'h83, 8'h88, {3'b011, COMP_SIX_BIT}},
		'{8'h80, 8'h01, {3'b111, COMP_SIX_BIT}},
		'{8'h83, 8'h00, {3'b100, COMP_SIX_BIT}}};

	shockproof_command_status_control i_dut (.i_clock(clock), .i_arst_n(arst_n),
		.i_host_shift_clock(sck), .i_host_serial_data(sdat), .i_host_latch_strobe(ld),
		.i_dsp_overflow_in(flag_in), .i_frame_clock_in(fclk), .i_block_clock_in(bclk),
		.i_mute_pin(mute), .i_ext_port_level(ext), .i_write_step(wstep), .i_read_step(rstep),
		.i_conform_detect(conf), .i_connect_done(cdone), .i_left_word_start(lws),
		.o_host_sense_out(sense), .o_ctrl(ctrl), .o_gain(gain), .o_write_pointer(wp),
		.o_read_pointer(rp), .o_valid_write_pointer(vwp));
	host_link_model i_host (.o_shift_clock(sck), .o_serial_data(sdat), .o_latch_strobe(ld),
		.i_sense(sense));

	// System clock.
	initial begin
		forever #5 clock = ~clock;
	end

	// Counts the one-cycle connect start pulses seen on the control output.
	always @(posedge clock) begin
		if (ctrl.connect_start === 1'b1) begin
			starts++;
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(input logic [17:0] g, input logic [17:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host.put(a, d);
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		i_host.get(a, w);
		cyc(1);
		chk(18'(w & m), 18'(e));
	endtask
	task automatic pulse(ref logic s, input int n);
		repeat (n) begin
			s = 1;
			cyc(1);
			s = 0;
			cyc(1);
		end
	endtask
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog against a hung handshake.
	initial begin
		#400000;
		fails++;
		complete_run();
	end

	// Reset, the table of writes, then the awkward sequences.
	initial begin
		cyc(2);
		arst_n = 1;
		chk(18'(gain), 18'h40);
		chk(wp | rp | vwp, 18'h0);
		chk(18'(ctrl.compress_mode), 18'(COMP_SIX_BIT));
		cyc(3);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].data);
			got = {ctrl.memory_system_on, ctrl.attenuator_enable, ctrl.reduced_compare, ctrl.compress_mode};
			chk(18'(got), 18'(rows[i].exp));
		end
		rd(8'h93, 8'hff, 8'h0a);
		ext = 4'h5;
		cyc(4);
		rd(8'h93, 8'hff, 8'h05);
		rd(8'h91, 8'hf0, 8'h80);
		pulse(wstep, 3);
		bclk = 0;
		cyc(4);
		bclk = 1;
		pulse(wstep, 1);
		wr(8'h80, 8'h23);
		chk(vwp, 18'h3);
		chk(18'(ctrl.decoding_state), 18'h1);
		pulse(rstep, 3);
		chk(18'(ctrl.decoding_state), 18'h0);
		rd(8'h90, 8'h02, 8'h02);
		rd(8'h90, 8'h02, 8'h00);
		bclk = 0;
		cyc(4);
		bclk = 1;
		wr(8'h80, 8'h23);
		chk(18'(ctrl.decoding_state), 18'h1);
		wr(8'h80, 8'h51);
		chk(wp | rp, 18'h0);
		pulse(rstep, 2);
		pulse(wstep, 2);
		rd(8'h90, 8'h44, 8'h44);
		rd(8'h90, 8'h40, 8'h00);
		rd(8'h91, 8'h40, 8'h40);
		pulse(rstep, 1);
		rd(8'h91, 8'h40, 8'h00);
		wr(8'h80, 8'h51);
		rd(8'h90, 8'h04, 8'h00);
		// Each capture mode: the edge modes see a wrong edge first, then the right one; the level modes set on the flag level before either edge.
		for (int m = 0; m < 4; m++) begin
			wr(8'h85, {2'b00, 2'(m), 4'h4});
			flag_in = (m != 3);
			fclk = m[0];
			cyc(5);
			i_host.get(8'h90, w);
			flag_in = (m == 3);
			cyc(5);
			fclk = ~fclk;
			cyc(5);
			rd(8'h90, 8'h80, {m[1], 7'h00});
			fclk = ~fclk;
			cyc(5);
			rd(8'h90, 8'h80, 8'h80);
		end
		flag_in = 0;
		cyc(5);
		wr(8'h80, 8'h00);
		rd(8'h90, 8'h80, 8'h00);
		wr(8'h80, 8'h80);
		chk(18'(ctrl.encoding_state), 18'h0);
		wr(8'h80, 8'h81);
		chk(18'(ctrl.encoding_state), 18'h1);
		wr(8'h80, 8'h0d);
		chk(18'({ctrl.encoding_state, ctrl.connect_mode}), 18'h3);
		rd(8'h90, 8'h08, 8'h08);
		pulse(conf, 1);
		chk(18'(ctrl.encoding_state), 18'h1);
		rd(8'h90, 8'h0c, 8'h00);
		wr(8'h80, 8'h89);
		chk(18'({ctrl.encoding_state, ctrl.connect_mode}), 18'h2);
		wr(8'h80, 8'h81);
		chk(18'(ctrl.encoding_state), 18'h1);
		rd(8'h90, 8'h08, 8'h00);
		wr(8'h80, 8'h05);
		chk(18'({ctrl.encoding_state, ctrl.connect_mode}), 18'h1);
		pulse(cdone, 1);
		chk(18'(ctrl.encoding_state), 18'h1);
		rd(8'h90, 8'h08, 8'h00);
		wr(8'h80, 8'h0d);
		wr(8'h80, 8'h01);
		rd(8'h90, 8'h08, 8'h00);
		wr(8'h84, 8'h20);
		wr(8'h83, 8'h80);
		pulse(lws, 1);
		chk(18'(gain), 18'h20);
		mute = 1;
		cyc(4);
		pulse(lws, 1);
		chk(18'(gain), 18'h0);
		mute = 0;
		cyc(4);
		pulse(lws, 1);
		chk(18'(gain), 18'h20);
		wr(8'h83, 8'ha0);
		pulse(lws, 2);
		chk(18'(gain), 18'h1e);
		wr(8'h83, 8'h00);
		pulse(lws, 1);
		chk(18'(gain), 18'h40);
		wr(8'h83, 8'h40);
		pulse(lws, 1);
		chk(18'(gain), 18'h0);
		chk(18'(starts), 18'h4);
		// Mid-run reset: state moved above must fall back to its reset values.
		pulse(wstep, 1);
		arst_n = 0;
		cyc(2);
		arst_n = 1;
		chk(wp | rp | vwp, 18'h0);
		chk(18'({ctrl.memory_system_on, ctrl.encoding_state, ctrl.connect_mode}), 18'h0);
		chk(18'(gain), 18'h40);
		cyc(3);
		rd(8'h90, 8'hff, 8'h00);
		complete_run();
	end
endmodule
